// ### fri_core.sv
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Flash rewrite sequencer: interrupt suspend, hold-off and forced reset
// Behaviour
// - Fatal interrupt while busy resets all three control registers.
// - Fatal interrupt, rewrite on and flash stopped resets registers.
// - Maskable interrupt request sets suspend request when both enables set.
// - Operation halts after suspend latency, then interrupt proceeds.
// - Erase suspended: access allowed except erasing block.
// - Program suspended: reads allowed except programming block.
// - Software clears suspend request; device resumes operation.
// - Without suspend, operation has priority; maskable interrupts held.
// - Fatal interrupt aborts, resets flash, restarts after fixed period.
// - Watchdog keeps counting; software refreshes it using erase-suspend.
module fri_core
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Interrupt controller side
    input  wire logic        i_mask_irq_req,
    input  wire logic        i_fatal_irq_req,
    output logic             o_mask_irq_ack,
    output logic             o_fatal_irq_ack,
    // Flash array access check
    input  wire logic        i_acc_valid,
    input  wire logic        i_acc_write,
    input  wire logic [3:0]  i_acc_block,
    output logic             o_acc_allow,
    // Flash engine status
    output logic             o_busy,
    output logic             o_flash_reset
);
    ////////////////////////////////////////////////////////////////////////
    // Registers and state
    logic [7:0]          flash_ctrl_reg_a;
    logic [7:0]          flash_ctrl_reg_b;
    logic [7:0]          flash_ctrl_reg_c;
    logic [3:0]          target_blk;
    fri_pkg::fri_state_t state;
    fri_pkg::fri_state_t susp_from;
    logic [7:0]          next_a;
    logic [7:0]          next_b;
    logic [7:0]          next_c;
    logic [3:0]          next_target;
    fri_pkg::fri_state_t next_state;
    fri_pkg::fri_state_t next_susp_from;
    logic [31:0]         next_prdata;
    logic                next_pready;
    logic                next_pslverr;
    logic                next_mack;
    logic                next_fack;
    logic                next_allow;
    logic                next_busy;
    logic                next_freset;
    logic                dly_load;
    logic [fri_pkg::CNT_W-1:0] dly_count;
    logic                dly_hold;
    logic                dly_done;
    logic [fri_pkg::CNT_W-1:0] lat_cnt;
    logic [fri_pkg::CNT_W-1:0] next_lat_cnt;
    logic                susp_lat_done;

    // Decoded fields
    logic cpu_rewrite_enable;
    logic flash_stop_bit;
    logic suspend_enable;
    logic suspend_request_flag;
    logic interrupt_suspend_enable;
    logic busy_now;
    logic wr_acc;
    logic rd_acc;

    assign cpu_rewrite_enable   = flash_ctrl_reg_a[fri_pkg::BIT_CPU_REWRITE];
    assign flash_stop_bit       = flash_ctrl_reg_a[fri_pkg::BIT_FLASH_STOP];
    assign suspend_enable       = flash_ctrl_reg_c[fri_pkg::BIT_SUSP_EN];
    assign suspend_request_flag = flash_ctrl_reg_c[fri_pkg::BIT_SUSP_REQ];
    assign interrupt_suspend_enable = flash_ctrl_reg_c[fri_pkg::BIT_INT_SUSP_EN];
    assign wr_acc = i_psel && i_penable && i_pwrite && o_pready;
    assign rd_acc = i_psel && !i_penable && !i_pwrite;

    // Busy from a decoded state; used by several decisions
    function automatic logic is_busy(input fri_pkg::fri_state_t s);
        is_busy = (s == fri_pkg::FRI_ERASE) || (s == fri_pkg::FRI_PROG)
               || (s == fri_pkg::FRI_SUSP_WAIT);
    endfunction

    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == fri_pkg::ADDR_CTRL_A) || (a == fri_pkg::ADDR_CTRL_B)
                  || (a == fri_pkg::ADDR_CTRL_C) || (a == fri_pkg::ADDR_CMD)
                  || (a == fri_pkg::ADDR_STATUS)
                  || (a == fri_pkg::ADDR_TARGET);
    endfunction

    assign busy_now = is_busy(state);

    ////////////////////////////////////////////////////////////////////////
    // Shared timer for erase, program and restart period
    fri_delay u_delay
    (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_load    (dly_load),
        .i_count   (dly_count),
        .i_hold    (dly_hold),
        .o_done    (dly_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer, registers and bus answer
    always_comb
    begin
        next_a         = flash_ctrl_reg_a;
        next_b         = flash_ctrl_reg_b;
        next_c         = flash_ctrl_reg_c;
        next_target    = target_blk;
        next_state     = state;
        next_susp_from = susp_from;
        next_mack      = 1'b0;
        next_fack      = 1'b0;
        next_freset    = 1'b0;
        dly_load       = 1'b0;
        dly_count      = '0;
        // APB: no wait states; answer in access phase
        next_pready    = i_psel && !i_penable;
        next_pslverr   = i_psel && !i_penable && !known_addr(i_paddr);
        next_prdata    = o_prdata;
        if (rd_acc)
        begin
            unique case (i_paddr)
                fri_pkg::ADDR_CTRL_A: next_prdata = {24'h000000, flash_ctrl_reg_a};
                fri_pkg::ADDR_CTRL_B: next_prdata = {24'h000000, flash_ctrl_reg_b};
                fri_pkg::ADDR_CTRL_C: next_prdata = {24'h000000, flash_ctrl_reg_c};
                fri_pkg::ADDR_STATUS: next_prdata = {29'h00000000, state};
                fri_pkg::ADDR_TARGET: next_prdata = {28'h0000000, target_blk};
                default:              next_prdata = 32'h00000000;
            endcase
        end

        // Register writes; command starts only from idle with flash running
        if (wr_acc)
        begin
            unique case (i_paddr)
                fri_pkg::ADDR_CTRL_A: next_a = i_pwdata[7:0];
                fri_pkg::ADDR_CTRL_B: next_b = i_pwdata[7:0];
                fri_pkg::ADDR_CTRL_C: next_c = i_pwdata[7:0];
                fri_pkg::ADDR_TARGET: next_target = i_pwdata[3:0];
                fri_pkg::ADDR_CMD:
                begin
                    if (state == fri_pkg::FRI_IDLE && cpu_rewrite_enable
                        && !flash_stop_bit)
                    begin
                        if (i_pwdata[fri_pkg::BIT_CMD_ERASE])
                        begin
                            next_state = fri_pkg::FRI_ERASE;
                            dly_load   = 1'b1;
                            dly_count  = fri_pkg::CNT_W'(fri_pkg::ERASE_CYC);
                        end
                        else if (i_pwdata[fri_pkg::BIT_CMD_PROG])
                        begin
                            next_state = fri_pkg::FRI_PROG;
                            dly_load   = 1'b1;
                            dly_count  = fri_pkg::CNT_W'(fri_pkg::PROG_CYC);
                        end
                    end
                end
                default: ;
            endcase
        end

        // Timer freezes only while suspended
        dly_hold = (state == fri_pkg::FRI_SUSPENDED);

        unique case (state)
            fri_pkg::FRI_IDLE:
            begin
                // Nothing running: maskable interrupts pass at once
                next_mack = i_mask_irq_req;
            end
            fri_pkg::FRI_ERASE,
            fri_pkg::FRI_PROG:
            begin
                if (dly_done)
                begin
                    next_state = fri_pkg::FRI_IDLE;
                end
                else if (i_mask_irq_req && suspend_enable
                         && interrupt_suspend_enable)
                begin
                    next_c[fri_pkg::BIT_SUSP_REQ] = 1'b1;
                    next_susp_from = state;
                    next_state     = fri_pkg::FRI_SUSP_WAIT;
                end
                else if (suspend_request_flag && suspend_enable)
                begin
                    // Software-driven suspend, e.g. to refresh the watchdog
                    next_susp_from = state;
                    next_state     = fri_pkg::FRI_SUSP_WAIT;
                end
                // Otherwise the maskable request stays pending
            end
            fri_pkg::FRI_SUSP_WAIT:
            begin
                // Engine keeps running during the latency, then parks
                dly_hold = 1'b0;
                if (dly_done)
                    next_state = fri_pkg::FRI_IDLE;
            end
            fri_pkg::FRI_SUSPENDED:
            begin
                next_mack = i_mask_irq_req;
                if (!suspend_request_flag)
                    next_state = susp_from;
            end
            fri_pkg::FRI_RESTART:
            begin
                next_freset = !dly_done;
                if (dly_done)
                begin
                    next_fack  = 1'b1;
                    next_state = fri_pkg::FRI_IDLE;
                end
            end
        endcase

        // Latency runs on its own count, lat_cnt, separate from the op timer
        if (state == fri_pkg::FRI_SUSP_WAIT && susp_lat_done)
            next_state = fri_pkg::FRI_SUSPENDED;

        // Fatal interrupts override all; the ack cycle is not a new request
        if (i_fatal_irq_req && !o_fatal_irq_ack
            && state != fri_pkg::FRI_RESTART)
        begin
            if (busy_now || state == fri_pkg::FRI_SUSPENDED
                || (cpu_rewrite_enable && flash_stop_bit))
            begin
                next_a = fri_pkg::RST_CTRL_A;
                next_b = fri_pkg::RST_CTRL_B;
                next_c = fri_pkg::RST_CTRL_C;
            end
            if (busy_now || state == fri_pkg::FRI_SUSPENDED)
            begin
                next_state  = fri_pkg::FRI_RESTART;
                next_freset = 1'b1;
                dly_load    = 1'b1;
                dly_count   = fri_pkg::CNT_W'(fri_pkg::RESTART_CYC);
            end
            else
                next_fack = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Suspend latency counter, separate so the op count is preserved

    always_comb
    begin
        next_lat_cnt = lat_cnt;
        if (state != fri_pkg::FRI_SUSP_WAIT)
            next_lat_cnt = fri_pkg::CNT_W'(fri_pkg::SUSP_LAT_CYC);
        else if (lat_cnt != '0)
            next_lat_cnt = lat_cnt - 1'b1;
    end
    assign susp_lat_done = (state == fri_pkg::FRI_SUSP_WAIT)
                        && (lat_cnt == {{(fri_pkg::CNT_W-1){1'b0}}, 1'b1});

    ////////////////////////////////////////////////////////////////////////
    // Access gate while suspended or busy
    always_comb
    begin
        next_busy  = is_busy(next_state) || next_state == fri_pkg::FRI_RESTART;
        next_allow = 1'b0;
        if (i_acc_valid)
        begin
            unique case (state)
                fri_pkg::FRI_IDLE: next_allow = 1'b1;
                fri_pkg::FRI_SUSPENDED:
                    if (susp_from == fri_pkg::FRI_ERASE)
                        next_allow = (i_acc_block != target_blk);
                    else
                        next_allow = !i_acc_write
                                  && (i_acc_block != target_blk);
                default: next_allow = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            flash_ctrl_reg_a <= fri_pkg::RST_CTRL_A;
            flash_ctrl_reg_b <= fri_pkg::RST_CTRL_B;
            flash_ctrl_reg_c <= fri_pkg::RST_CTRL_C;
            target_blk       <= '0;
            state            <= fri_pkg::FRI_IDLE;
            susp_from        <= fri_pkg::FRI_ERASE;
            lat_cnt          <= '0;
            o_prdata         <= '0;
            o_pready         <= 1'b0;
            o_pslverr        <= 1'b0;
            o_mask_irq_ack   <= 1'b0;
            o_fatal_irq_ack  <= 1'b0;
            o_acc_allow      <= 1'b0;
            o_busy           <= 1'b0;
            o_flash_reset    <= 1'b0;
        end
        else
        begin
            flash_ctrl_reg_a <= next_a;
            flash_ctrl_reg_b <= next_b;
            flash_ctrl_reg_c <= next_c;
            target_blk       <= next_target;
            state            <= next_state;
            susp_from        <= next_susp_from;
            lat_cnt          <= next_lat_cnt;
            o_prdata         <= next_prdata;
            o_pready         <= next_pready;
            o_pslverr        <= next_pslverr;
            o_mask_irq_ack   <= next_mack;
            o_fatal_irq_ack  <= next_fack;
            o_acc_allow      <= next_allow;
            o_busy           <= next_busy;
            o_flash_reset    <= next_freset;
        end
    end
endmodule

// ### fri_core_checker.sv
// Checker: port-level assertions for the flash rewrite sequencer
`timescale 1ns/1ps
module fri_core_checker
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Inputs watched
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_mask_irq_req,
    input wire logic i_fatal_irq_req,
    input wire logic i_acc_valid,
    // Outputs watched
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_mask_irq_ack,
    input wire logic o_fatal_irq_ack,
    input wire logic o_acc_allow,
    input wire logic o_busy,
    input wire logic o_flash_reset
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    // Restart: quiet for a while, then the late acknowledge
    sequence s_restart;
        !o_fatal_irq_ack [*8] ##[1:40] o_fatal_irq_ack;
    endsequence

    ////////////////////////////////////////////////////////////////////
    ready_after_setup_a: assert property (i_psel && !i_penable |=> o_pready)
        else $error("pready missing after setup");
    ready_one_cycle_a: assert property (o_pready |=> !o_pready)
        else $error("pready held too long");
    err_with_ready_a: assert property (o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    mask_ack_idle_a: assert property (o_mask_irq_ack |-> !o_busy)
        else $error("maskable ack while operation busy");
    mask_ack_cause_a: assert property (o_mask_irq_ack |-> $past(i_mask_irq_req))
        else $error("maskable ack without request");
    fatal_reset_a: assert property ($rose(i_fatal_irq_req) && o_busy |-> ##[1:2] o_flash_reset)
        else $error("flash not reset on fatal interrupt");
    restart_delay_a: assert property ($rose(o_flash_reset) |-> s_restart)
        else $error("fatal ack timing after flash reset wrong");
    fatal_pulse_a: assert property (o_fatal_irq_ack |=> !o_fatal_irq_ack)
        else $error("fatal ack longer than one cycle");
    allow_cause_a: assert property (o_acc_allow |-> $past(i_acc_valid))
        else $error("access allowed without query");
endmodule

bind fri_core fri_core_checker i_chk
(
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_mask_irq_req(i_mask_irq_req),
    .i_fatal_irq_req(i_fatal_irq_req), .i_acc_valid(i_acc_valid),
    .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_mask_irq_ack(o_mask_irq_ack), .o_fatal_irq_ack(o_fatal_irq_ack),
    .o_acc_allow(o_acc_allow), .o_busy(o_busy),
    .o_flash_reset(o_flash_reset)
);

// ### fri_core_tb_top.sv
// Testbench: APB, interrupts and flash queries into the sequencer
`timescale 1ns/1ps
module fri_core_tb_top;
    logic        clk, rst, psel, pen, pwr, pready, perr, err;
    logic        mreq, freq, mack, fack, rmask, rfatal;
    logic        av, aw, allow, busy, frst;
    logic [3:0]  ablk;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    int          error_cnt, num_checks, k;
    int          cyc = 0;
    localparam logic [31:0] C_SE = 32'h1 << fri_pkg::BIT_SUSP_EN;
    localparam logic [31:0] C_IE = 32'h1 << fri_pkg::BIT_INT_SUSP_EN;
    localparam logic [31:0] C_RQ = 32'h1 << fri_pkg::BIT_SUSP_REQ;
    localparam logic [31:0] A_RW = 32'h1 << fri_pkg::BIT_CPU_REWRITE;
    localparam logic [31:0] A_ST = 32'h1 << fri_pkg::BIT_FLASH_STOP;

    fri_core i_dut
    (
        .i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr),
        .i_mask_irq_req(mreq), .i_fatal_irq_req(freq),
        .o_mask_irq_ack(mack), .o_fatal_irq_ack(fack),
        .i_acc_valid(av), .i_acc_write(aw), .i_acc_block(ablk),
        .o_acc_allow(allow), .o_busy(busy), .o_flash_reset(frst)
    );

    fri_cpu_model i_cpu
    (
        .i_clk_sys(clk), .i_rst(rst), .i_raise_mask(rmask),
        .i_raise_fatal(rfatal), .i_mask_ack(mack), .i_fatal_ack(fack),
        .o_mask_req(mreq), .o_fatal_req(freq)
    );

    // 10 MHz clock
    always #50 clk = ~clk;

    // Hang guard: a handful of erases fits well below the ceiling
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            report_and_stop;
        end
    end

    ////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL %0t seen %h expected %h", $time, got, exp);
        end
    endtask

    task report_and_stop;
        if (error_cnt == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // APB master: request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // No local cap: only the bench timeout ends a hung transfer
        do
            @(posedge clk);
        while (pready !== 1'b1);
        q = prdata;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    task regs_clear;
        rdchk(fri_pkg::ADDR_CTRL_A, {24'h0, fri_pkg::RST_CTRL_A});
        rdchk(fri_pkg::ADDR_CTRL_B, {24'h0, fri_pkg::RST_CTRL_B});
        rdchk(fri_pkg::ADDR_CTRL_C, {24'h0, fri_pkg::RST_CTRL_C});
    endtask

    function logic pick(input int s);
        case (s)
            0: return busy;
            1: return mack;
            2: return fack;
            default: return frst;
        endcase
    endfunction

    // Bounded wait on a status output; k holds the cycles spent
    task wait_on(input int s, input logic v);
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pick(s) !== v && k < 3000);
        chk(pick(s), v);
    endtask

    task raise(input logic f);
        @(posedge clk);
        rmask <= ~f;
        rfatal <= f;
        @(posedge clk);
        rmask <= 1'b0;
        rfatal <= 1'b0;
    endtask

    // Access query; the answer is registered one cycle later
    task query(input logic w, input logic [3:0] b, input logic e);
        @(posedge clk);
        av <= 1'b1;
        aw <= w;
        ablk <= b;
        @(posedge clk);
        av <= 1'b0;
        @(posedge clk);
        chk(allow, e);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Interrupt-driven suspend of an erase or program, then resume
    task t_susp(input int op);
        apb(1'b1, fri_pkg::ADDR_CTRL_C, C_SE | C_IE);
        apb(1'b1, fri_pkg::ADDR_CMD, 32'h1 << op);
        raise(1'b0);
        wait_on(1, 1'b1);
        chk(k >= fri_pkg::SUSP_LAT_CYC, 1'b1);
        rdchk(fri_pkg::ADDR_CTRL_C, C_SE | C_IE | C_RQ);
        query(1'b0, 4'h3, 1'b0);
        query(1'b0, 4'h5, 1'b1);
        if (op == fri_pkg::BIT_CMD_ERASE)
        begin
            query(1'b1, 4'h3, 1'b0);
            query(1'b1, 4'h5, 1'b1);
        end
        else
            query(1'b1, 4'h5, 1'b0);
        apb(1'b1, fri_pkg::ADDR_CTRL_C, C_SE | C_IE);
        wait_on(0, 1'b1);
        wait_on(0, 1'b0);
    endtask

    // Maskable interrupt held until a program completes
    task t_hold(input logic [31:0] c);
        apb(1'b1, fri_pkg::ADDR_CTRL_C, c);
        apb(1'b1, fri_pkg::ADDR_CMD, 32'h1 << fri_pkg::BIT_CMD_PROG);
        raise(1'b0);
        wait_on(1, 1'b1);
        chk(k >= fri_pkg::PROG_CYC / 2, 1'b1);
        chk(k <= fri_pkg::PROG_CYC + 4, 1'b1);
        rdchk(fri_pkg::ADDR_CTRL_C, c);
    endtask

    // Software suspend, as used to refresh the watchdog mid-erase
    task t_wdog;
        apb(1'b1, fri_pkg::ADDR_CTRL_C, C_SE);
        apb(1'b1, fri_pkg::ADDR_CMD, 32'h1 << fri_pkg::BIT_CMD_ERASE);
        apb(1'b1, fri_pkg::ADDR_CTRL_C, C_SE | C_RQ);
        wait_on(0, 1'b0);
        chk(k <= fri_pkg::SUSP_LAT_CYC + 3, 1'b1);
        apb(1'b1, fri_pkg::ADDR_CTRL_C, C_SE);
        wait_on(0, 1'b1);
        wait_on(0, 1'b0);
    endtask

    // Fatal interrupt mid-erase, then set up again and rerun the erase
    task t_fatal;
        apb(1'b1, fri_pkg::ADDR_CTRL_C, C_SE | C_IE);
        apb(1'b1, fri_pkg::ADDR_CMD, 32'h1 << fri_pkg::BIT_CMD_ERASE);
        raise(1'b1);
        wait_on(3, 1'b1);
        wait_on(2, 1'b1);
        chk(k >= fri_pkg::RESTART_CYC - 1, 1'b1);
        regs_clear;
        apb(1'b1, fri_pkg::ADDR_CTRL_A, A_RW);
        apb(1'b1, fri_pkg::ADDR_CMD, 32'h1 << fri_pkg::BIT_CMD_ERASE);
        wait_on(0, 1'b1);
        wait_on(0, 1'b0);
    endtask

    // Fatal interrupt while idle with rewrite enabled and flash stopped
    task t_stop;
        apb(1'b1, fri_pkg::ADDR_CTRL_C, C_SE);
        apb(1'b1, fri_pkg::ADDR_CTRL_A, A_RW | A_ST);
        raise(1'b1);
        wait_on(2, 1'b1);
        regs_clear;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        {clk, psel, pen, pwr, rmask, rfatal, av, aw} = 8'h00;
        rst = 1'b1;
        ablk = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        error_cnt = 0;
        num_checks = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        regs_clear;
        apb(1'b0, 8'h3c, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, fri_pkg::ADDR_TARGET, 32'h3);
        apb(1'b1, fri_pkg::ADDR_CTRL_A, A_RW);
        t_susp(fri_pkg::BIT_CMD_ERASE);
        t_susp(fri_pkg::BIT_CMD_PROG);
        t_hold(32'h0);
        t_hold(C_SE);
        t_hold(C_IE);
        t_wdog;
        t_fatal;
        t_stop;
        report_and_stop;
    end
endmodule

// ### fri_cpu_model.sv
// Partner model: interrupt controller holding requests until acked
`timescale 1ns/1ps
module fri_cpu_model
(
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    // Software raises a source for one cycle
    input  wire logic i_raise_mask,
    input  wire logic i_raise_fatal,
    // Device answers
    input  wire logic i_mask_ack,
    input  wire logic i_fatal_ack,
    // Level requests to the device
    output logic      o_mask_req,
    output logic      o_fatal_req
);
    logic next_mask_req;
    logic next_fatal_req;

    // A request stays pending until the device takes it; only maskable
    // and fatal sources exist, no traps or single-step
    always_comb
    begin
        next_mask_req  = (o_mask_req & ~i_mask_ack) | i_raise_mask;
        next_fatal_req = (o_fatal_req & ~i_fatal_ack) | i_raise_fatal;
    end

    // Request registers
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_mask_req  <= 1'b0;
            o_fatal_req <= 1'b0;
        end
        else
        begin
            o_mask_req  <= next_mask_req;
            o_fatal_req <= next_fatal_req;
        end
    end
endmodule

// ### fri_delay.sv
`timescale 1ns/1ps
// Down counter that pulses done when a loaded count expires
module fri_delay
(
    // Clock and reset
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_rst,
    // Control
    input  wire logic                    i_load,
    input  wire logic [fri_pkg::CNT_W-1:0] i_count,
    input  wire logic                    i_hold,
    // Status
    output logic                         o_done
);
    logic [fri_pkg::CNT_W-1:0] cnt;
    logic [fri_pkg::CNT_W-1:0] next_cnt;
    logic                      next_done;

    // Load wins; hold freezes a running count (used while suspended)
    always_comb
    begin
        next_cnt  = cnt;
        next_done = 1'b0;
        if (i_load)
            next_cnt = i_count;
        else if (!i_hold && cnt != '0)
        begin
            next_cnt  = cnt - 1'b1;
            next_done = (cnt == {{(fri_pkg::CNT_W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt    <= '0;
            o_done <= 1'b0;
        end
        else
        begin
            cnt    <= next_cnt;
            o_done <= next_done;
        end
    end
endmodule

// ### fri_pkg.sv
// Package: register map, field positions, reset values and timing for the block
package fri_pkg;
    // APB byte addresses
    localparam logic [7:0] ADDR_CTRL_A = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B = 8'h04;
    localparam logic [7:0] ADDR_CTRL_C = 8'h08;
    localparam logic [7:0] ADDR_CMD    = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_TARGET = 8'h14;
    // Control register A fields
    localparam int BIT_CPU_REWRITE = 1;
    localparam int BIT_FLASH_STOP  = 7;
    // Control register C fields
    localparam int BIT_SUSP_EN     = 0;
    localparam int BIT_SUSP_REQ    = 1;
    localparam int BIT_INT_SUSP_EN = 2;
    // Command register fields
    localparam int BIT_CMD_ERASE   = 0;
    localparam int BIT_CMD_PROG    = 1;
    // Reset values
    localparam logic [7:0] RST_CTRL_A = 8'h00;
    localparam logic [7:0] RST_CTRL_B = 8'h00;
    localparam logic [7:0] RST_CTRL_C = 8'h00;
    // Timing
    localparam int CLK_NS            = 100;
    localparam int SUSP_LAT_NS       = 1000;
    localparam int RESTART_NS        = 3000;
    localparam int SUSP_LAT_CYC      = SUSP_LAT_NS / CLK_NS;
    localparam int RESTART_CYC       = RESTART_NS / CLK_NS;
    localparam int ERASE_CYC         = 400;
    localparam int PROG_CYC          = 40;
    localparam int CNT_W             = 12;
    localparam int BLK_W             = 4;
    typedef enum logic [2:0] {
        FRI_IDLE, FRI_ERASE, FRI_PROG, FRI_SUSP_WAIT, FRI_SUSPENDED,
        FRI_RESTART
    } fri_state_t;
endpackage
